// ===== src/lsd_ctrl.v
// Serial shift, latches, mode switch and error readout of the LED sink driver
//
// How it works
// - Normal mode shifts serial_in each edge; oldest bit leaves on serial_out.
// - Normal mode: output latch follows shift register while latch_strobe high.
// - Sinks follow output latch while output_enable_n low, all off otherwise.
// - Enable pattern 101 on edges starts a two-period mode switch phase.
// - Fourth edge: latch_strobe high selects Special, low selects Normal.
// - Latch strobe latches nothing between third and fifth switch edges.
// - Shifting continues during switching; short enable pulse still drives sinks.
// - Power-up mode is Normal.
// - Entering Normal mode clears all channel error status; sinks are off on that edge, so no fault is kept.
// - Special mode with enable high shifts exactly like Normal mode.
// - After second low sample, shift source becomes parallel status code.
// - Third and later low samples parallel-load status, ignoring serial_in.
// - Enable high ends detection, disables sinks, restores serial source.
// - Special mode: latch_strobe writes configuration latch, not output latch.
// - Configuration kept until rewritten; controller avoids latching status.
// - Config bit0 multiplier, bit1 exponent, bits2-7 mantissa; 15:8 ignored.
// - Mantissa bit0 is most significant; gain from exponent and mantissa.
// - Multiplier set gives ratio 15, clear gives ratio 5.
// - Power-up configuration is all eight bits one.
// - Status one for healthy enabled channel, zero otherwise, sticky overtemp.
`timescale 1ns/100ps
`include "lsd_map.vh"
`default_nettype none
module lsd_ctrl (
   input  wire        sys_clk,
   input  wire        arst_n,
   input  wire        serial_in,
   input  wire        latch_strobe,
   input  wire        output_enable_n,
   input  wire [15:0] fault_now,
   output wire        serial_out,
   output wire [15:0] sink_drive,
   output wire        special_mode,
   output wire        current_multiplier,
   output wire        gain_exponent,
   output wire [5:0]  gain_mantissa,
   output wire [7:0]  current_gain_config
);
   reg              rst_m_r;
   reg              rst_r;
   wire             sdi_s;
   wire             le_s;
   wire             oen_s;
   reg  [15:0]      shift_r;
   reg  [15:0]      shift_nxt;
   reg  [15:0]      out_latch_r;
   reg  [15:0]      out_latch_nxt;
   reg  [7:0]       cfg_r;
   reg  [7:0]       cfg_nxt;
   reg              special_r;
   reg              special_nxt;
   reg  [2:0]       ms_r;
   reg  [2:0]       ms_nxt;
   reg              oen_d_r;
   reg  [1:0]       low_cnt_r;
   reg  [1:0]       low_cnt_nxt;
   reg  [15:0]      sink_r;
   reg              err_clear;
   wire [15:0]      status;
   wire             le_blocked;

   // Saturating count of consecutive low samples
   function [1:0] sat_inc;
      input [1:0] v;
      begin
         sat_inc = (v == `LSD_LOW_LOAD) ? v : v + 2'h1;
      end
   endfunction

   // Reset release through two flops
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_m_r <= 1'b0;
         rst_r   <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_r   <= rst_m_r;
      end
   end

   // Pin synchronisers
   lsd_sync #(.RST_VAL(1'b0)) u_sdi (
      .sys_clk (sys_clk),
      .rst_n   (rst_r),
      .d       (serial_in),
      .q       (sdi_s)
   );
   lsd_sync #(.RST_VAL(1'b0)) u_le (
      .sys_clk (sys_clk),
      .rst_n   (rst_r),
      .d       (latch_strobe),
      .q       (le_s)
   );
   lsd_sync #(.RST_VAL(1'b1)) u_oen (
      .sys_clk (sys_clk),
      .rst_n   (rst_r),
      .d       (output_enable_n),
      .q       (oen_s)
   );

   // Sticky channel error status
   lsd_err_status u_err (
      .sys_clk   (sys_clk),
      .rst_n     (rst_r),
      .clear     (err_clear),
      .sink_on   (sink_r),
      .fault_now (fault_now),
      .status    (status)
   );

   assign le_blocked = (ms_nxt == `LSD_MS_SW1) || (ms_r == `LSD_MS_SW1) ||
                       (ms_r == `LSD_MS_SW2);

   // Mode switch detector
   always @* begin
      ms_nxt      = `LSD_MS_IDLE;
      special_nxt = special_r;
      err_clear   = 1'b0;
      case (ms_r)
         `LSD_MS_IDLE: begin
            if (oen_s) begin
               ms_nxt = `LSD_MS_HIGH1;
            end
         end
         `LSD_MS_HIGH1: begin
            if (!oen_s) begin
               ms_nxt = `LSD_MS_LOW;
            end else begin
               ms_nxt = `LSD_MS_HIGH1;
            end
         end
         `LSD_MS_LOW: begin
            if (oen_s) begin
               ms_nxt = `LSD_MS_SW1;
            end else begin
               ms_nxt = `LSD_MS_IDLE;
            end
         end
         `LSD_MS_SW1: begin
            ms_nxt      = `LSD_MS_SW2;
            special_nxt = le_s;
            err_clear   = !le_s;
         end
         `LSD_MS_SW2: begin
            ms_nxt = oen_s ? `LSD_MS_HIGH1 : `LSD_MS_IDLE;
         end
         default: begin
            ms_nxt = `LSD_MS_IDLE;
         end
      endcase
   end

   // Shift source, latches and low-sample counter
   always @* begin
      shift_nxt     = {shift_r[14:0], sdi_s};
      out_latch_nxt = out_latch_r;
      cfg_nxt       = cfg_r;
      low_cnt_nxt   = 2'h0;
      if (special_r && !oen_s) begin
         low_cnt_nxt = sat_inc(low_cnt_r);
         if (low_cnt_r >= `LSD_LOW_SWAP) begin
            shift_nxt = status;
         end
      end
      if (le_s && !le_blocked) begin
         if (special_r) begin
            cfg_nxt = shift_nxt[7:0];
         end else begin
            out_latch_nxt = shift_nxt;
         end
      end
   end

   // State registers
   always @(posedge sys_clk or negedge rst_r) begin
      if (!rst_r) begin
         shift_r     <= 16'h0000;
         out_latch_r <= 16'h0000;
         cfg_r       <= `LSD_CFG_RST;
         special_r   <= 1'b0;
         ms_r        <= `LSD_MS_IDLE;
         oen_d_r     <= 1'b1;
         low_cnt_r   <= 2'h0;
         sink_r      <= 16'h0000;
      end else begin
         shift_r     <= shift_nxt;
         out_latch_r <= out_latch_nxt;
         cfg_r       <= cfg_nxt;
         special_r   <= special_nxt;
         ms_r        <= ms_nxt;
         oen_d_r     <= oen_s;
         low_cnt_r   <= low_cnt_nxt;
         // Sinks gated by enable, pulse included
         sink_r      <= oen_s ? 16'h0000 : out_latch_nxt;
      end
   end

   assign serial_out          = shift_r[`LSD_NCH-1];
   assign sink_drive          = sink_r;
   assign special_mode        = special_r;
   assign current_gain_config = cfg_r;
   // Multiplier bit picks ratio 15 or 5
   assign current_multiplier  = cfg_r[`LSD_CFG_CM];
   assign gain_exponent       = cfg_r[`LSD_CFG_HC];
   // Mantissa bit0 in config bit2, most significant
   assign gain_mantissa       = cfg_r[`LSD_CFG_MANT_H:`LSD_CFG_MANT_L];
endmodule
`default_nettype wire

// ===== src/lsd_map.vh
// Constants for the LED sink serial and mode control block
`ifndef LSD_MAP_VH
`define LSD_MAP_VH
`define LSD_NCH        16
`define LSD_CFG_W      8
`define LSD_CFG_RST    8'hff
`define LSD_CFG_CM     0
`define LSD_CFG_HC     1
`define LSD_CFG_MANT_H 7
`define LSD_CFG_MANT_L 2
`define LSD_MS_W       3
`define LSD_MS_IDLE    3'h0
`define LSD_MS_HIGH1   3'h1
`define LSD_MS_LOW     3'h2
`define LSD_MS_SW1     3'h3
`define LSD_MS_SW2     3'h4
`define LSD_LOWCNT_W   2
`define LSD_LOW_SWAP   2'h2
`define LSD_LOW_LOAD   2'h3
`define LSD_STAT_OK    16'hffff
`endif

// ===== src/lsd_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module lsd_sync #(
   parameter RST_VAL = 1'b0
) (
   input  wire sys_clk,
   input  wire rst_n,
   input  wire d,
   output wire q
);
   reg meta_r;
   reg q_r;

   // First flop feeds only the second
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         q_r    <= RST_VAL;
      end else begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

// ===== src/lsd_err_status.v
// Per-channel sticky error status registers
`timescale 1ns/100ps
`include "lsd_map.vh"
`default_nettype none
module lsd_err_status (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        clear,
   input  wire [15:0] sink_on,
   input  wire [15:0] fault_now,
   output wire [15:0] status
);
   reg [15:0] stick_r;

   // Faults stick until the Normal-mode clear; a new fault beats the clear
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stick_r <= 16'h0000;
      end else if (clear) begin
         stick_r <= sink_on & fault_now;
      end else begin
         stick_r <= stick_r | (sink_on & fault_now);
      end
   end

   assign status = sink_on & ~fault_now & ~stick_r;
endmodule
`default_nettype wire

// ===== testbench/lsd_ctrl_asserts.sv
// Pin-level assertions for the LED sink serial control block
`timescale 1ns/100ps
`default_nettype none
module lsd_ctrl_checker (
   input wire logic       sys_clk,
   input wire logic       arst_n,
   input wire logic       serial_in,
   input wire logic       latch_strobe,
   input wire logic       output_enable_n,
   input wire logic       serial_out,
   input wire logic [15:0] sink_drive,
   input wire logic       special_mode,
   input wire logic       current_multiplier,
   input wire logic       gain_exponent,
   input wire logic [5:0] gain_mantissa,
   input wire logic [7:0] current_gain_config
);
   logic [4:0] norm_cnt_r;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // Cycles in Normal mode, saturating
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) norm_cnt_r <= 5'h00;
      else if (special_mode) norm_cnt_r <= 5'h00;
      else if (norm_cnt_r != 5'h1f) norm_cnt_r <= norm_cnt_r + 5'h01;
   end
   // Short enable pulse 101
   sequence sw_head;
      output_enable_n ##1 !output_enable_n ##1 output_enable_n;
   endsequence
   a_chain_delay: assert property (norm_cnt_r > 5'h18 |-> serial_out == $past(serial_in, 18))
      else $error("serial chain delay wrong");
   a_sinks_off: assert property (output_enable_n[*6] |-> sink_drive == 16'h0000)
      else $error("sinks on while disabled");
   a_mode_quiet: assert property (output_enable_n[*8] |=> $stable(special_mode))
      else $error("mode moved without pulse");
   a_to_special: assert property (sw_head ##1 (output_enable_n && latch_strobe) |-> ##[2:5] special_mode)
      else $error("special mode not entered");
   a_to_normal: assert property (sw_head ##1 (output_enable_n && !latch_strobe) |-> ##[2:5] !special_mode)
      else $error("normal mode not entered");
   a_cfg_hold: assert property (!latch_strobe[*6] |=> $stable(current_gain_config))
      else $error("config moved without strobe");
   a_cfg_normal: assert property (!special_mode[*7] |-> $stable(current_gain_config))
      else $error("config written in normal mode");
   a_latch_special: assert property ((special_mode && !output_enable_n)[*7] |-> $stable(sink_drive))
      else $error("output latch written in special mode");
   a_cfg_fields: assert property ({gain_mantissa, gain_exponent, current_multiplier} == current_gain_config)
      else $error("config fields misplaced");
endmodule
bind lsd_ctrl lsd_ctrl_checker i_chk (.sys_clk(sys_clk), .arst_n(arst_n), .serial_in(serial_in),
   .latch_strobe(latch_strobe), .output_enable_n(output_enable_n), .serial_out(serial_out),
   .sink_drive(sink_drive), .special_mode(special_mode), .current_multiplier(current_multiplier),
   .gain_exponent(gain_exponent), .gain_mantissa(gain_mantissa),
   .current_gain_config(current_gain_config));
`default_nettype wire

// ===== testbench/lsd_mcu_model.sv
// Controller model driving the serial pins of the sink driver
`timescale 1ns/100ps
`default_nettype none
module lsd_mcu (
   input  wire logic sys_clk,
   input  wire logic serial_out,
   output var  logic serial_in,
   output var  logic latch_strobe,
   output var  logic output_enable_n
);
   logic [63:0] seen = 64'h0;
   initial begin
      serial_in = 1'b0;
      latch_strobe = 1'b0;
      output_enable_n = 1'b1;
   end
   // One clock: log serial_out, then drive pins
   task automatic tick(input logic si, input logic le, input logic oe);
      @(posedge sys_clk);
      #1;
      seen = {seen[62:0], serial_out};
      serial_in = si;
      latch_strobe = le;
      output_enable_n = oe;
   endtask
   task automatic idle(input logic oe, input int n);
      for (int i = 0; i < n; i++) tick(1'b0, 1'b0, oe);
   endtask
   // word sent first bit high, strobe with last bit
   task automatic word(input logic [15:0] w, input logic le);
      for (int i = 15; i >= 0; i--) tick(w[i], le && i == 0, 1'b1);
   endtask
   // pulse 101, strobe level picks mode
   task automatic pulse(input logic sel);
      for (int i = 0; i < 6; i++) tick(1'b0, sel && (i == 3 || i == 4), i != 1);
   endtask
   // enable low 84 cycles, no data
   task automatic readout();
      idle(1'b0, 84);
   endtask
endmodule
`default_nettype wire

// ===== testbench/lsd_ctrl_bench.sv
// Self-checking bench for the LED sink serial control block
`timescale 1ns/100ps
`default_nettype none
module lsd_ctrl_bench;
   logic       sys_clk, arst_n, serial_in, latch_strobe, output_enable_n, serial_out;
   logic       special_mode, current_multiplier, gain_exponent;
   logic [15:0] fault_now, sink_drive;
   logic [5:0] gain_mantissa;
   logic [7:0] current_gain_config;
   int         bad_count = 0;
   int         num_checks = 0;
   lsd_ctrl i_lsd_ctrl (.*);
   lsd_mcu i_lsd_mcu (.*);
   // Clock at 40 MHz
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic summarize();
      if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // Search the logged serial output for a bit pattern
   function automatic logic [15:0] found(input logic [31:0] v, input int n);
      logic [63:0] m;
      m = (64'h1 << n) - 64'h1;
      found = 16'h0;
      for (int k = 0; k < 33; k++) if (((i_lsd_mcu.seen >> k) & m) === ({32'h0, v} & m)) found = 16'h1;
   endfunction
   // Hang guard
   initial begin
      #100000;
      bad_count++;
      summarize();
   end
   initial begin
      arst_n = 1'b0;
      fault_now = 16'h0000;
      repeat (8) @(posedge sys_clk);
      #1 arst_n = 1'b1;
      i_lsd_mcu.idle(1'b1, 5);
      chk("mode", 16'h0, {15'h0, special_mode});
      chk("cfg", 16'h00ff, {8'h0, current_gain_config});
      i_lsd_mcu.word(16'ha5c3, 1'b0);
      i_lsd_mcu.word(16'h3cf0, 1'b1);
      i_lsd_mcu.word(16'h0000, 1'b0);
      i_lsd_mcu.idle(1'b1, 4);
      chk("chain", 16'h1, found({16'ha5c3, 16'h3cf0}, 32));
      chk("sink off", 16'h0, sink_drive);
      i_lsd_mcu.idle(1'b0, 4);
      chk("sink on", 16'h3cf0, sink_drive);
      i_lsd_mcu.idle(1'b1, 4);
      i_lsd_mcu.pulse(1'b1);
      i_lsd_mcu.idle(1'b1, 4);
      chk("special", 16'h1, {15'h0, special_mode});
      i_lsd_mcu.word(16'hab34, 1'b1);
      i_lsd_mcu.idle(1'b0, 4);
      chk("sink kept", 16'h3cf0, sink_drive);
      chk("cfg", 16'h0034, {8'h0, current_gain_config});
      chk("fields", 16'h0034, {8'h0, gain_mantissa, gain_exponent, current_multiplier});
      i_lsd_mcu.idle(1'b1, 4);
      fault_now = 16'h0030;
      i_lsd_mcu.readout();
      fault_now = 16'h0000;
      i_lsd_mcu.word(16'h0000, 1'b0);
      i_lsd_mcu.idle(1'b1, 4);
      chk("status", 16'h1, found(32'h3cc0, 16));
      chk("sink idle", 16'h0, sink_drive);
      chk("cfg kept", 16'h0034, {8'h0, current_gain_config});
      i_lsd_mcu.tick(1'b0, 1'b0, 1'b0);
      i_lsd_mcu.tick(1'b0, 1'b0, 1'b0);
      i_lsd_mcu.idle(1'b1, 6);
      chk("long low", 16'h1, {15'h0, special_mode});
      i_lsd_mcu.pulse(1'b0);
      i_lsd_mcu.idle(1'b1, 4);
      chk("normal", 16'h0, {15'h0, special_mode});
      i_lsd_mcu.pulse(1'b1);
      i_lsd_mcu.readout();
      i_lsd_mcu.word(16'h0000, 1'b0);
      i_lsd_mcu.idle(1'b1, 4);
      chk("cleared", 16'h1, found(32'h3cf0, 16));
      summarize();
   end
endmodule
`default_nettype wire
